// file: inc/flash_host_pkg.sv
// Purpose: shared constants, opcodes and types of the parallel flash controller
// Assumes: 250 MHz system clock, word-wide flash data bus
// Notes: bus timing figures are plain defaults, adjust to the part in use
package flash_host_pkg;

  localparam int CLK_MHZ = 250;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // pin timing in ns and derived clock counts (least times round up)
  localparam int WE_LOW_NS = 35;
  localparam int WE_HIGH_NS = 20;
  localparam int RD_ACC_NS = 70;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WE_LOW_CYC = ns_to_cyc(WE_LOW_NS);
  localparam int WE_HIGH_CYC = ns_to_cyc(WE_HIGH_NS);
  localparam int RD_ACC_CYC = ns_to_cyc(RD_ACC_NS);

  // register offsets of the controller's own port
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;

  // config bits
  localparam int CFG_BYTE = 0;
  localparam int CFG_AUTOPOLL = 1;
  localparam int CFG_HWRST = 2;
  localparam logic [2:0] CFG_RESET = 3'h2;

  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_BYPASS = 4;
  localparam int ST_ERASE = 5;
  localparam int ST_SUSP = 6;
  localparam int ST_PROT = 7;
  localparam int ST_W = 8;

  // flash data bit positions
  localparam int POLL_BIT = 7;
  localparam int TOUT_BIT = 5;

  // command data bytes
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [7:0] CMD_SUSP = 8'hB0;
  localparam logic [7:0] CMD_SSEC = 8'h88;

  // unlock and query addresses, word and byte mode
  localparam logic [11:0] A_UNLK1_W = 12'h0555;
  localparam logic [11:0] A_UNLK1_B = 12'h0AAA;
  localparam logic [11:0] A_UNLK2_W = 12'h02AA;
  localparam logic [11:0] A_UNLK2_B = 12'h0555;
  localparam logic [11:0] A_QRY_W = 12'h0055;
  localparam logic [11:0] A_QRY_B = 12'h00AA;
  localparam logic [11:0] A_PROT_W = 12'h0002;
  localparam logic [11:0] A_PROT_B = 12'h0004;
  localparam int SECT_LSB = 12;

  typedef enum logic [4:0] {
    OP_READ, OP_RESET, OP_AUTOSEL, OP_PROT_VERIFY, OP_QUERY, OP_PROGRAM,
    OP_BYP_ENTER, OP_BYP_PROG, OP_BYP_EXIT, OP_CHIP_ERASE, OP_SECT_ERASE,
    OP_SECT_ADD, OP_SUSPEND, OP_RESUME, OP_SS_ENTER, OP_SS_EXIT, OP_POLL
  } op_e;

  typedef enum logic [2:0] {
    AK_ANY, AK_UNLK1, AK_UNLK2, AK_QRY, AK_USER, AK_SECT, AK_PROT
  } akind_e;

  typedef struct packed {
    akind_e kind;
    logic [7:0] data;
    logic user_data;
    logic rd;
    logic last;
  } step_s;

endpackage

// file: inc/flash_cycle_if.sv
// Purpose: carries one flash bus cycle request and its answer
// Assumes: req is a one-cycle pulse, ack a one-cycle pulse
// Notes: rdata is valid only with ack of a read
`timescale 1ns/1ps
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic ack;
  logic [DATA_W-1:0] rdata;
  modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// file: hdl/flash_bus_cycle.sv
// Purpose: drives one asynchronous write or read cycle on the flash pins
// Assumes: flash data input is asynchronous to i_clk
// Notes: address and data stay stable over the whole strobe
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int WE_LOW = WE_LOW_CYC,
  parameter int WE_HIGH = WE_HIGH_CYC,
  parameter int RD_ACC = RD_ACC_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // request side
  flash_cycle_if.engine cyc,
  // flash pins
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_dq_o,
  output logic o_dq_oe,
  output logic o_ce_b,
  output logic o_oe_b,
  output logic o_we_b,
  input wire logic [DATA_W-1:0] i_dq
);

  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} cst_e;
  cst_e st_q;
  logic [7:0] cnt_q;
  logic wr_q;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q;

  // three-stage sampler; only s2/s3 are compared
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_dq;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // cycle sequencer: address latched at strobe fall, data at strobe rise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= C_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      o_addr <= '0;
      o_dq_o <= '0;
      o_dq_oe <= 1'b0;
      o_ce_b <= 1'b1;
      o_oe_b <= 1'b1;
      o_we_b <= 1'b1;
      cyc.ack <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      cyc.ack <= 1'b0;
      case (st_q)
        C_IDLE: begin
          if (cyc.req) begin
            wr_q <= cyc.wr;
            o_addr <= cyc.addr;
            o_dq_o <= cyc.wdata;
            o_dq_oe <= cyc.wr;
            o_ce_b <= 1'b0;
            st_q <= C_SETUP;
          end
        end
        C_SETUP: begin
          o_we_b <= ~wr_q;
          o_oe_b <= wr_q;
          cnt_q <= '0;
          st_q <= C_STROBE;
        end
        C_STROBE: begin
          cnt_q <= cnt_q + 8'd1;
          if (wr_q && cnt_q >= 8'(WE_LOW - 1)) begin
            o_we_b <= 1'b1; // data taken here, still driven
            cnt_q <= '0;
            st_q <= C_HOLD;
          end else if (!wr_q && cnt_q >= 8'(RD_ACC + 1) && s2_q == s3_q) begin
            // wait for the sampler to settle, a changing poll bit just delays us
            cyc.rdata <= s3_q;
            o_oe_b <= 1'b1;
            cnt_q <= '0;
            st_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          o_ce_b <= 1'b1;
          cnt_q <= cnt_q + 8'd1;
          if (cnt_q >= 8'(WE_HIGH - 1)) begin
            o_dq_oe <= 1'b0;
            cyc.ack <= 1'b1;
            st_q <= C_IDLE;
          end
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end

endmodule

// file: hdl/flash_host_ctrl.sv
// Purpose: host-side controller issuing command sequences to a parallel NOR flash
// Assumes: software drives a simple register port, one command at a time
// Notes: status polling uses the completion and timeout bits of the read data
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // flash pins
  output logic [ADDR_W-1:0] o_flash_addr,
  output logic [DATA_W-1:0] o_flash_dq_o,
  output logic o_flash_dq_oe,
  output logic o_flash_ce_b,
  output logic o_flash_oe_b,
  output logic o_flash_we_b,
  output logic o_flash_reset_b,
  input wire logic [DATA_W-1:0] i_flash_dq
);

  typedef enum logic [2:0] {
    S_IDLE, S_SEQ, S_SEQW, S_POLL, S_POLLW, S_RECHKW, S_FINW, S_RECOVW
  } st_e;

  flash_cycle_if cyc ();

  st_e st_q;
  op_e op_q;
  logic [2:0] idx_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic [2:0] cfg_q;
  logic done_q, fail_q, refused_q, prot_q;
  logic bypass_q, erase_q, susp_q;
  logic poll_exp_q;
  logic [ADDR_W-1:0] poll_addr_q;
  logic req_q, wr_q;
  logic [ADDR_W-1:0] caddr_q;
  logic [DATA_W-1:0] cdata_q;
  logic cmd_wr;
  op_e cmd_op;
  logic cmd_ok;
  step_s step;
  logic [ST_W-1:0] status;

  // one row of a command sequence
  function automatic step_s seq_step(input op_e op, input logic [2:0] idx);
    step_s s;
    s = '{AK_ANY, CMD_RESET, 1'b0, 1'b0, 1'b1};
    if (idx == 3'd0) begin
      s = '{AK_UNLK1, CMD_UNLK1, 1'b0, 1'b0, 1'b0};
    end else if (idx == 3'd1) begin
      s = '{AK_UNLK2, CMD_UNLK2, 1'b0, 1'b0, 1'b0};
    end
    case (op)
      OP_READ: s = '{AK_USER, 8'h00, 1'b0, 1'b1, 1'b1};
      OP_RESET: s = '{AK_ANY, CMD_RESET, 1'b0, 1'b0, 1'b1};
      OP_AUTOSEL, OP_PROT_VERIFY: begin
        if (idx == 3'd2) s = '{AK_UNLK1, CMD_AUTOSEL, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd3) begin
          // fourth cycle reads
          s = '{(op == OP_AUTOSEL) ? AK_USER : AK_PROT, 8'h00, 1'b0, 1'b1, 1'b1};
        end
      end
      OP_QUERY: s = '{AK_QRY, CMD_QUERY, 1'b0, 1'b0, 1'b1};
      OP_PROGRAM: begin
        if (idx == 3'd2) s = '{AK_UNLK1, CMD_PROG, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd3) s = '{AK_USER, 8'h00, 1'b1, 1'b0, 1'b1};
      end
      OP_BYP_ENTER: if (idx == 3'd2) s = '{AK_UNLK1, CMD_BYPASS, 1'b0, 1'b0, 1'b1};
      OP_BYP_PROG: begin
        if (idx == 3'd0) s = '{AK_ANY, CMD_PROG, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd1) s = '{AK_USER, 8'h00, 1'b1, 1'b0, 1'b1};
      end
      OP_BYP_EXIT: begin
        if (idx == 3'd0) s = '{AK_ANY, CMD_AUTOSEL, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd1) s = '{AK_ANY, CMD_EXIT2, 1'b0, 1'b0, 1'b1};
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        if (idx == 3'd2) s = '{AK_UNLK1, CMD_ERASE, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd3) s = '{AK_UNLK1, CMD_UNLK1, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd4) s = '{AK_UNLK2, CMD_UNLK2, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd5) begin
          s = (op == OP_CHIP_ERASE) ? step_s'{AK_UNLK1, CMD_CHIP, 1'b0, 1'b0, 1'b1}
                                    : step_s'{AK_SECT, CMD_SECT, 1'b0, 1'b0, 1'b1};
        end
      end
      OP_SECT_ADD: s = '{AK_SECT, CMD_SECT, 1'b0, 1'b0, 1'b1};
      OP_SUSPEND: s = '{AK_ANY, CMD_SUSP, 1'b0, 1'b0, 1'b1};
      OP_RESUME: s = '{AK_ANY, CMD_SECT, 1'b0, 1'b0, 1'b1};
      OP_SS_ENTER: if (idx == 3'd2) s = '{AK_UNLK1, CMD_SSEC, 1'b0, 1'b0, 1'b1};
      OP_SS_EXIT: begin
        if (idx == 3'd2) s = '{AK_UNLK1, CMD_AUTOSEL, 1'b0, 1'b0, 1'b0};
        if (idx == 3'd3) s = '{AK_ANY, CMD_EXIT2, 1'b0, 1'b0, 1'b1};
      end
      default: s = '{AK_ANY, CMD_RESET, 1'b0, 1'b0, 1'b1};
    endcase
    return s;
  endfunction

  // pin address of a step; unlock and query cycles keep upper bits at zero, sector steps keep the sector bits
  function automatic logic [ADDR_W-1:0] step_addr(input akind_e k, input logic byte_m,
                                                   input logic [ADDR_W-1:0] ua);
    logic [ADDR_W-1:0] a;
    a = '0;
    case (k)
      AK_UNLK1: a = ADDR_W'(byte_m ? A_UNLK1_B : A_UNLK1_W);
      AK_UNLK2: a = ADDR_W'(byte_m ? A_UNLK2_B : A_UNLK2_W);
      AK_QRY: a = ADDR_W'(byte_m ? A_QRY_B : A_QRY_W);
      AK_USER: a = ua;
      AK_SECT: a = {ua[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}};
      AK_PROT: a = {ua[ADDR_W-1:SECT_LSB], byte_m ? A_PROT_B : A_PROT_W};
      default: a = '0;
    endcase
    return a;
  endfunction

  function automatic logic is_prog(input op_e op);
    return (op == OP_PROGRAM) || (op == OP_BYP_PROG);
  endfunction

  assign step = seq_step(op_q, idx_q);
  assign cmd_wr = i_reg_wr && (i_reg_addr == REG_CMD);
  assign cmd_op = op_e'(i_reg_wdata[4:0]);

  // commands the flash would not act on in the present mode are refused here
  always_comb begin
    cmd_ok = (st_q == S_IDLE);
    case (cmd_op)
      OP_BYP_PROG, OP_BYP_EXIT: cmd_ok = cmd_ok && bypass_q;
      OP_QUERY: cmd_ok = cmd_ok && !bypass_q && !erase_q;
      OP_SUSPEND: cmd_ok = cmd_ok && erase_q && !susp_q;
      OP_RESUME: cmd_ok = cmd_ok && susp_q;
      OP_SECT_ADD: cmd_ok = cmd_ok && erase_q && !susp_q;
      OP_POLL: cmd_ok = cmd_ok && (erase_q || is_prog(op_q));
      OP_PROGRAM, OP_READ, OP_RESET, OP_AUTOSEL, OP_PROT_VERIFY: cmd_ok = cmd_ok;
      OP_BYP_ENTER, OP_CHIP_ERASE, OP_SECT_ERASE, OP_SS_ENTER, OP_SS_EXIT: begin
        cmd_ok = cmd_ok && !erase_q;
      end
      default: cmd_ok = 1'b0;
    endcase
  end

  // plain configuration and operand registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= CFG_RESET;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == REG_CFG) cfg_q <= i_reg_wdata[2:0];
      if (i_reg_addr == REG_ADDR) addr_q <= i_reg_wdata[ADDR_W-1:0];
      if (i_reg_addr == REG_WDATA) wdata_q <= i_reg_wdata[DATA_W-1:0];
    end
  end

  // hardware reset pin follows its config bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flash_reset_b <= 1'b1;
    end else begin
      o_flash_reset_b <= ~cfg_q[CFG_HWRST];
    end
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  assign status = {prot_q, susp_q, erase_q, bypass_q, refused_q, fail_q, done_q,
                   st_q != S_IDLE};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= '0;
    end else begin
      o_reg_rdata <= '0;
      if (i_reg_rd) begin
        case (i_reg_addr)
          REG_CMD: o_reg_rdata <= 32'(op_q);
          REG_ADDR: o_reg_rdata <= 32'(addr_q);
          REG_WDATA: o_reg_rdata <= 32'(wdata_q);
          REG_CFG: o_reg_rdata <= 32'(cfg_q);
          REG_STATUS: o_reg_rdata <= 32'(status);
          REG_RDATA: o_reg_rdata <= 32'(rdata_q);
          default: o_reg_rdata <= '0;
        endcase
      end
    end
  end

  // cycle requests to the pin engine
  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = caddr_q;
  assign cyc.wdata = cdata_q;

  // main sequencer: command rows, then completion polling
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= S_IDLE;
      op_q <= OP_READ;
      idx_q <= '0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      caddr_q <= '0;
      cdata_q <= '0;
      rdata_q <= '0;
      poll_exp_q <= 1'b1;
      poll_addr_q <= '0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      refused_q <= 1'b0;
      prot_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (cmd_wr && cmd_ok) begin
            op_q <= (cmd_op == OP_POLL) ? op_q : cmd_op;
            idx_q <= '0;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            refused_q <= 1'b0;
            st_q <= (cmd_op == OP_POLL) ? S_POLL : S_SEQ;
          end else if (cmd_wr) begin
            refused_q <= 1'b1;
          end
        end
        S_SEQ: begin
          req_q <= 1'b1;
          wr_q <= ~step.rd;
          caddr_q <= step_addr(step.kind, cfg_q[CFG_BYTE], addr_q);
          // command bytes leave the upper data byte at zero
          cdata_q <= step.user_data ? wdata_q : DATA_W'(step.data);
          st_q <= S_SEQW;
        end
        S_SEQW: begin
          if (cyc.ack) begin
            if (step.rd) begin
              rdata_q <= cyc.rdata;
              if (op_q == OP_PROT_VERIFY) prot_q <= cyc.rdata[0];
            end
            if (!step.last) begin
              idx_q <= idx_q + 3'd1;
              st_q <= S_SEQ;
            end else if (is_prog(op_q) || op_q == OP_CHIP_ERASE || op_q == OP_SECT_ERASE) begin
              // program expects true bit 7, erase expects 1
              poll_exp_q <= is_prog(op_q) ? wdata_q[POLL_BIT] : 1'b1;
              poll_addr_q <= is_prog(op_q) ? addr_q
                           : step_addr(AK_SECT, cfg_q[CFG_BYTE], addr_q);
              st_q <= cfg_q[CFG_AUTOPOLL] ? S_POLL : S_IDLE;
              done_q <= ~cfg_q[CFG_AUTOPOLL];
            end else begin
              st_q <= S_IDLE;
              done_q <= 1'b1;
            end
          end
        end
        S_POLL: begin
          req_q <= 1'b1;
          wr_q <= 1'b0;
          caddr_q <= poll_addr_q;
          st_q <= S_POLLW;
        end
        S_POLLW, S_RECHKW: begin
          if (cyc.ack) begin
            req_q <= 1'b1; // next cycle goes out at once, a read or the recovery reset write
            if (cyc.rdata[POLL_BIT] == poll_exp_q) begin
              // bit 7 may lead bits 6..0, take data next read
              st_q <= S_FINW;
            end else if (st_q == S_RECHKW) begin
              // still not done after timeout bit: recover with reset
              wr_q <= 1'b1;
              caddr_q <= '0;
              cdata_q <= DATA_W'(CMD_RESET);
              st_q <= S_RECOVW;
            end else if (cyc.rdata[TOUT_BIT]) begin
              st_q <= S_RECHKW;
            end
          end
        end
        S_FINW: begin
          if (cyc.ack) begin
            rdata_q <= cyc.rdata;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        S_RECOVW: begin
          if (cyc.ack) begin
            fail_q <= 1'b1;
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // mode tracking mirrors what the flash believes it is in
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bypass_q <= 1'b0;
      erase_q <= 1'b0;
      susp_q <= 1'b0;
    end else if (!o_flash_reset_b || st_q == S_RECOVW) begin
      // a reset pulse or the recovery reset write drops every mode
      bypass_q <= 1'b0;
      erase_q <= 1'b0;
      susp_q <= 1'b0;
    end else if (st_q == S_SEQW && cyc.ack && step.last) begin
      case (op_q)
        OP_BYP_ENTER: bypass_q <= 1'b1;
        OP_BYP_EXIT, OP_RESET: bypass_q <= 1'b0;
        OP_SECT_ERASE: erase_q <= 1'b1;
        OP_SUSPEND: susp_q <= 1'b1;
        OP_RESUME: susp_q <= 1'b0;
        default: bypass_q <= bypass_q;
      endcase
    end else if (st_q == S_FINW && cyc.ack && !is_prog(op_q)) begin
      erase_q <= 1'b0; // erase finished or all sectors protected
    end
  end

  flash_bus_cycle u_cycle (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .cyc(cyc.engine),
    .o_addr(o_flash_addr),
    .o_dq_o(o_flash_dq_o),
    .o_dq_oe(o_flash_dq_oe),
    .o_ce_b(o_flash_ce_b),
    .o_oe_b(o_flash_oe_b),
    .o_we_b(o_flash_we_b),
    .i_dq(i_flash_dq)
  );

endmodule

// file: sim/flash_host_monitor.sv
// Purpose: pin relations of the flash controller
// Assumes: one clock, async active-low reset
// Notes: bound to every flash_host_ctrl
`timescale 1ns/1ps
module flash_host_monitor
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // flash pins
  input wire logic [ADDR_W-1:0] o_flash_addr,
  input wire logic [DATA_W-1:0] o_flash_dq_o,
  input wire logic o_flash_dq_oe,
  input wire logic o_flash_ce_b,
  input wire logic o_flash_oe_b,
  input wire logic o_flash_we_b
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // cycle framing and data direction
  property p_we_ce; !o_flash_we_b |-> !o_flash_ce_b; endproperty
  a_we_ce: assert property (p_we_ce) else $error("strobe outside chip enable");
  property p_rw; !o_flash_we_b |-> o_flash_oe_b; endproperty
  a_rw: assert property (p_rw) else $error("read and write at once");
  property p_oe_dq; !o_flash_oe_b |-> !o_flash_dq_oe; endproperty
  a_oe_dq: assert property (p_oe_dq) else $error("driving data in read");
  property p_we_dq; !o_flash_we_b |-> o_flash_dq_oe; endproperty
  a_we_dq: assert property (p_we_dq) else $error("write without data");
  // address held through the whole cycle, data held to the strobe rise
  property p_addr; !o_flash_ce_b && $past(!o_flash_ce_b) |-> $stable(o_flash_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in cycle");
  property p_data; $rose(o_flash_we_b) |-> $stable(o_flash_dq_o); endproperty
  a_data: assert property (p_data) else $error("data moved at strobe rise");
  // strobe width and idle gap, short pulses risk a missed latch
  property p_wlen; $fell(o_flash_we_b) |-> !o_flash_we_b [*8]; endproperty
  a_wlen: assert property (p_wlen) else $error("write strobe too short");
  property p_gap; $rose(o_flash_ce_b) |-> o_flash_ce_b [*5]; endproperty
  a_gap: assert property (p_gap) else $error("cycles too close");
  c_wr: cover property ($fell(o_flash_we_b));
  c_rd: cover property ($fell(o_flash_oe_b));
  c_end: cover property ($rose(o_flash_ce_b));
endmodule
bind flash_host_ctrl flash_host_monitor mon (.i_clk, .i_rst_b, .o_flash_addr, .o_flash_dq_o,
  .o_flash_dq_oe, .o_flash_ce_b, .o_flash_oe_b, .o_flash_we_b);

// file: sim/flash_model.sv
// Purpose: behavioural flash answering writes and polls
// Assumes: one stored word answers every read
// Notes: status stays for three reads, forever on timeout
`timescale 1ns/1ps
module flash_model
  import flash_host_pkg::*;
(
  // pins
  input wire logic i_ce_b,
  input wire logic i_oe_b,
  input wire logic i_we_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  // forces the pulse-limit failure
  input wire logic i_tout,
  output logic [DATA_W-1:0] o_dq
);
  logic [ADDR_W-1:0] wa[$];
  logic [DATA_W-1:0] wd[$];
  logic [ADDR_W-1:0] la;
  logic [DATA_W-1:0] mem = 16'h0000;
  logic [DATA_W-1:0] v;
  logic ers = 1'b0;
  logic asel = 1'b0;
  int busy = 0;
  // address at strobe fall, data at strobe rise
  always @(negedge i_we_b) la = i_addr;
  always @(posedge i_we_b) begin
    wa.push_back(la);
    wd.push_back(i_dq);
    if (wd.size() > 1 && wd[wd.size()-2][7:0] == 8'hA0) begin
      mem = i_dq;
      busy = 3;
      ers = 1'b0;
    end else if (wd.size() > 1 && wd[wd.size()-2][7:0] == 8'h55 &&
                 (i_dq[7:0] == 8'h30 || i_dq[7:0] == 8'h10)) begin
      // erased words read all ones once the status ends
      mem = 16'hFFFF;
      busy = 3;
      ers = 1'b1;
    end else if (wd.size() > 1 && wd[wd.size()-2][7:0] == 8'h55 && i_dq[7:0] == 8'h90) begin
      asel = 1'b1;
    end else if (i_dq[7:0] == 8'hF0) begin
      busy = 0;
      asel = 1'b0;
    end
  end
  // a failed operation never finishes on its own
  always @(posedge i_oe_b) if (busy > 0 && !i_tout) busy--;
  // inverse bit then true value, erase shows 0; odd sectors protected, an arbitrary map
  always_comb begin
    v = mem;
    if (busy > 0) v = {8'h00, ers ? 1'b0 : ~mem[7], 1'b0, i_tout, 5'h00};
    if (asel) v = {15'h0000, i_addr[SECT_LSB]};
  end
  // released bus shows the inverse so stale data never matches
  assign o_dq = (!i_ce_b && !i_oe_b) ? v : ~v;
endmodule

// file: sim/tb_top.sv
// Purpose: random and corner tests of the flash controller
// Assumes: model answers polls after three reads
// Notes: expected cycles built from command tables here
`timescale 1ns/1ps
module tb_top
  import flash_host_pkg::*;
;
  logic i_clk = 0, i_rst_b = 0, wr = 0, rd = 0, tout = 0;
  logic [7:0] ra = 8'h00;
  logic [31:0] wd = 32'h0000_0000, rdat, s;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] fdo, fdi;
  logic oe, ce, oeb, web, rstb;
  logic [19:0] a;
  logic [15:0] d;
  int n_mismatch = 0, checked = 0;
  initial forever #2 i_clk = ~i_clk;
  flash_host_ctrl dut (.i_clk, .i_rst_b, .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdat), .o_flash_addr(fa), .o_flash_dq_o(fdo),
    .o_flash_dq_oe(oe), .o_flash_ce_b(ce), .o_flash_oe_b(oeb), .o_flash_we_b(web),
    .o_flash_reset_b(rstb), .i_flash_dq(fdi));
  flash_model fm (.i_ce_b(ce), .i_oe_b(oeb), .i_we_b(web), .i_addr(fa), .i_dq(fdo),
    .i_tout(tout), .o_dq(fdi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] v);
    @(posedge i_clk);
    ra <= ad;
    wd <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] ad, output logic [31:0] v);
    @(posedge i_clk);
    ra <= ad;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1 v = rdat;
  endtask
  // start an op, then poll status until idle
  task automatic op(input logic [4:0] c);
    int k;
    wreg(REG_CMD, {27'h0, c});
    k = 0;
    s = 32'h0000_0001;
    while (s[0] === 1'b1 && k < 3000) begin
      rreg(REG_STATUS, s);
      k++;
    end
    // a hang counts as a mismatch
    if (k >= 3000) n_mismatch++;
  endtask
  function automatic logic [19:0] ua(input logic bm, input logic sec);
    return {8'h00, sec ? (bm ? A_UNLK2_B : A_UNLK2_W) : (bm ? A_UNLK1_B : A_UNLK1_W)};
  endfunction
  // k-th write from the end as seen by the flash
  task automatic cw(input int k, input logic [19:0] ea, input logic [15:0] ed);
    chk({12'h0, fm.wa[fm.wa.size()-k]}, {12'h0, ea});
    chk({16'h0, fm.wd[fm.wd.size()-k]}, {16'h0, ed});
  endtask
  task automatic prog(input logic bm);
    a = 20'($urandom);
    d = 16'($urandom);
    wreg(REG_CFG, {29'h0, 2'b01, bm});
    wreg(REG_ADDR, {12'h0, a});
    wreg(REG_WDATA, {16'h0, d});
    op(5'd5);
    cw(4, ua(bm, 0), 16'h00AA);
    cw(3, ua(bm, 1), 16'h0055);
    cw(2, ua(bm, 0), 16'h00A0);
    cw(1, a, d);
    chk({29'h0, s[2:0]}, 32'h2);
    rreg(REG_RDATA, s);
    chk(s, {16'h0, d});
  endtask
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h2e6b_3d86));
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rreg(REG_CFG, s);
    chk(s, {29'h0, CFG_RESET});
    rreg(8'h18, s);
    chk(s, 32'h0);
    repeat (3) prog(1'b0);
    prog(1'b1);
    wreg(REG_CFG, 32'h6);
    @(posedge i_clk);
    #1 chk({31'h0, rstb}, 32'h0);
    wreg(REG_CFG, 32'h2);
    op(5'd7);
    chk({31'h0, s[3]}, 32'h1);
    op(5'd6);
    chk({31'h0, s[4]}, 32'h1);
    op(5'd7);
    cw(1, a, d);
    op(5'd8);
    chk({31'h0, s[4]}, 32'h0);
    cw(1, 20'h0_0000, 16'h0000);
    op(5'd4);
    cw(1, {8'h00, A_QRY_W}, 16'h0098);
    op(5'd3);
    chk({31'h0, s[7]}, {31'h0, a[SECT_LSB]});
    op(5'd1);
    chk({16'h0, fm.wd[fm.wd.size()-1]}, 32'hF0);
    op(5'd10);
    cw(1, {a[19:12], 12'h000}, 16'h0030);
    cw(4, ua(0, 0), 16'h0080);
    chk({31'h0, s[1]}, 32'h1);
    op(5'd12);
    chk({31'h0, s[3]}, 32'h1);
    // erase left pending: add a sector, suspend, resume, then poll it out
    wreg(REG_CFG, 32'h0);
    op(5'd10);
    chk({31'h0, s[5]}, 32'h1);
    op(5'd11);
    cw(1, {a[19:12], 12'h000}, 16'h0030);
    op(5'd12);
    chk({30'h0, s[6], s[3]}, 32'h2);
    op(5'd13);
    chk({30'h0, s[6], s[3]}, 32'h0);
    cw(1, 20'h0_0000, 16'h0030);
    wreg(REG_CFG, 32'h2);
    op(5'd16);
    chk({30'h0, s[5], s[1]}, 32'h1);
    op(5'd9);
    cw(1, ua(0, 0), 16'h0010);
    wreg(REG_WDATA, 32'h0011);
    tout <= 1'b1;
    op(5'd5);
    chk({31'h0, s[2]}, 32'h1);
    chk({16'h0, fm.wd[fm.wd.size()-1]}, 32'hF0);
    print_verdict();
  end
endmodule
